// [abu_pkg.sv]
// package of constants and carrier types for the address breakpoint unit
package abu_pkg;
    // register word offsets on the avalon bus (word addresses)
    localparam logic [3:0] ADDR_BRK_SC = 4'h0;
    localparam logic [3:0] ADDR_MATCH_HI = 4'h1;
    localparam logic [3:0] ADDR_MATCH_LO = 4'h2;
    localparam logic [3:0] ADDR_WAIT_EXIT = 4'h3;
    localparam logic [3:0] ADDR_FLAG_CLR = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
    // field positions
    localparam int BIT_ENABLE = 7;
    localparam int BIT_ACTIVE = 6;
    localparam int BIT_WAIT_EXIT = 1;
    localparam int BIT_STOP_WAIT = 0;
    localparam int BIT_FLAG_PERMIT = 7;
    localparam int BIT_EV_BREAK = 0;
    localparam int BIT_EV_WAKE = 1;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_EV = 2'h0;
    // vectors for the software interrupt fetch
    localparam logic [15:0] VEC_NORMAL = 16'hfffc;
    localparam logic [15:0] VEC_MONITOR = 16'hfefc;
    // opcode injected into the instruction register, value arbitrary here
    localparam logic [7:0] SWI_OPCODE = 8'h83;

    typedef struct packed {
        logic [15:0] pc_addr;
        logic pc_valid;
        logic instr_last;
        logic rti_done;
    } abu_cpu_type;

    typedef struct packed {
        logic req;
        logic [7:0] opcode;
        logic [15:0] vector;
    } abu_brk_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PEND = 3'b010,
        ST_BREAK = 3'b100
    } abu_state_type;
endpackage

// [abu_top.sv]
// address breakpoint unit with avalon-mm register slave
// What this block does
// - pc address equal to match address raises a breakpoint request
// - break injects software interrupt opcode, vector fffc or fefc in monitor mode
// - writing 1 to the active flag starts a break like a match
// - break starts after current instruction, at once if match on last cycle
// - return from interrupt in the handler ends the break state
// - during a break the timers freeze and ignore captures
// - during a break the watchdog is off when test voltage is present
// - break in stop mode wakes the part and sets stop/wait exit indication
// - enable bit 7 gates 16-bit address matches, reset clears it
// - active flag set on match, cleared by reset, software clears it
// - two byte registers hold match address halves, reset zero
// - wait exit flag set when break leaves wait, cleared by writing 0
// - status clearing during break only when permit bit is 1
// - comparison keeps working in wait mode
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module abu_top (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // processor side
    input wire abu_pkg::abu_cpu_type cpu_in,
    input wire logic monitor_mode,
    input wire logic in_wait,
    input wire logic in_stop,
    input wire logic test_voltage_pin,
    // break request and side effects
    output abu_pkg::abu_brk_type brk_out,
    output logic break_active,
    output logic timer_freeze,
    output logic watchdog_disable,
    output logic wake_req,
    output logic flag_clear_permit_out,
    // interrupt
    output logic irq
);
    abu_pkg::abu_state_type state_r, state_nxt;
    logic enable_r;
    logic active_r;
    logic [7:0] match_hi_r;
    logic [7:0] match_lo_r;
    logic wait_exit_r;
    logic stop_wait_r;
    logic permit_r;
    logic [1:0] ev_stat_r;
    logic [1:0] ev_mask_r;
    logic ack_r;
    logic [2:0] tv_sync_r;
    logic test_v;
    logic wr_acc, rd_acc;
    logic addr_hit;
    logic sw_trigger;
    logic trigger;
    logic break_start;
    logic [1:0] ev_set;

    function automatic logic is_wr(input logic [3:0] a, input logic [3:0] want);
        is_wr = (a == want);
    endfunction

    // one wait state per access keeps readdata registered; a write lands at the acknowledging edge
    assign wr_acc = avs_write && ack_r && clk_en;
    assign rd_acc = avs_read && !ack_r && clk_en;
    // a frozen clock enable holds the bus in wait so no access is lost
    assign avs_waitrequest = (avs_read || avs_write) && !(ack_r && clk_en);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else if (clk_en) begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end

    // test voltage on reset pin is asynchronous: three flops, act when last two agree
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tv_sync_r <= 3'h0;
        end else if (clk_en) begin
            tv_sync_r <= {tv_sync_r[1:0], test_voltage_pin};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            test_v <= 1'b0;
        end else if (clk_en && (tv_sync_r[2] == tv_sync_r[1])) begin
            test_v <= tv_sync_r[2];
        end
    end

    // comparison runs in wait mode too; only the enable and pc_valid gate it
    assign addr_hit = enable_r && cpu_in.pc_valid
        && (cpu_in.pc_addr == {match_hi_r, match_lo_r});
    assign sw_trigger = wr_acc && is_wr(avs_address, abu_pkg::ADDR_BRK_SC)
        && avs_writedata[abu_pkg::BIT_ACTIVE] && !active_r;
    assign trigger = (addr_hit || sw_trigger) && (state_r == abu_pkg::ST_IDLE);

    // break waits for the instruction boundary; a hit on the last cycle starts now
    always_comb begin
        state_nxt = state_r;
        break_start = 1'b0;
        case (state_r)
            abu_pkg::ST_IDLE: begin
                if (trigger) begin
                    if (cpu_in.instr_last) begin
                        state_nxt = abu_pkg::ST_BREAK;
                        break_start = 1'b1;
                    end else begin
                        state_nxt = abu_pkg::ST_PEND;
                    end
                end
            end
            abu_pkg::ST_PEND: begin
                if (cpu_in.instr_last) begin
                    state_nxt = abu_pkg::ST_BREAK;
                    break_start = 1'b1;
                end
            end
            abu_pkg::ST_BREAK: begin
                if (cpu_in.rti_done) begin
                    state_nxt = abu_pkg::ST_IDLE;
                end
            end
            default: state_nxt = abu_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= abu_pkg::ST_IDLE;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    // breakpoint status/control register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            enable_r <= 1'b0;
            active_r <= 1'b0;
        end else if (clk_en) begin
            if (wr_acc && is_wr(avs_address, abu_pkg::ADDR_BRK_SC)) begin
                enable_r <= avs_writedata[abu_pkg::BIT_ENABLE];
            end
            // a match in the same cycle as a clear keeps the flag set
            if (addr_hit || sw_trigger) begin
                active_r <= 1'b1;
            end else if (wr_acc && is_wr(avs_address, abu_pkg::ADDR_BRK_SC)) begin
                active_r <= avs_writedata[abu_pkg::BIT_ACTIVE];
            end
        end
    end

    // match address halves
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            match_hi_r <= abu_pkg::RST_BYTE;
            match_lo_r <= abu_pkg::RST_BYTE;
        end else if (clk_en && wr_acc) begin
            if (is_wr(avs_address, abu_pkg::ADDR_MATCH_HI)) begin
                match_hi_r <= avs_writedata[7:0];
            end
            if (is_wr(avs_address, abu_pkg::ADDR_MATCH_LO)) begin
                match_lo_r <= avs_writedata[7:0];
            end
        end
    end

    // wait/stop exit flags: set wins over a write of 0
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_exit_r <= 1'b0;
            stop_wait_r <= 1'b0;
        end else if (clk_en) begin
            if (break_start && in_wait) begin
                wait_exit_r <= 1'b1;
            end else if (wr_acc && is_wr(avs_address, abu_pkg::ADDR_WAIT_EXIT)
                         && !avs_writedata[abu_pkg::BIT_WAIT_EXIT]) begin
                wait_exit_r <= 1'b0;
            end
            if (break_start && (in_wait || in_stop)) begin
                stop_wait_r <= 1'b1;
            end else if (wr_acc && is_wr(avs_address, abu_pkg::ADDR_WAIT_EXIT)
                         && !avs_writedata[abu_pkg::BIT_STOP_WAIT]) begin
                stop_wait_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            permit_r <= 1'b0;
        end else if (clk_en && wr_acc && is_wr(avs_address, abu_pkg::ADDR_FLAG_CLR)) begin
            permit_r <= avs_writedata[abu_pkg::BIT_FLAG_PERMIT];
        end
    end

    // interrupt status: sticky, write one to clear, set wins
    assign ev_set[abu_pkg::BIT_EV_BREAK] = break_start;
    assign ev_set[abu_pkg::BIT_EV_WAKE] = break_start && (in_wait || in_stop);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ev_stat_r <= abu_pkg::RST_EV;
            ev_mask_r <= abu_pkg::RST_EV;
        end else if (clk_en) begin
            if (wr_acc && is_wr(avs_address, abu_pkg::ADDR_IRQ_STAT)) begin
                ev_stat_r <= (ev_stat_r & ~avs_writedata[1:0]) | ev_set;
            end else begin
                ev_stat_r <= ev_stat_r | ev_set;
            end
            if (wr_acc && is_wr(avs_address, abu_pkg::ADDR_IRQ_MASK)) begin
                ev_mask_r <= avs_writedata[1:0];
            end
        end
    end

    assign irq = |(ev_stat_r & ev_mask_r);

    // read data registered at the wait-state edge, one edge before the acknowledging edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0;
        end else if (rd_acc) begin
            case (avs_address)
                abu_pkg::ADDR_BRK_SC: avs_readdata <= {24'h0, enable_r, active_r, 6'h0};
                abu_pkg::ADDR_MATCH_HI: avs_readdata <= {24'h0, match_hi_r};
                abu_pkg::ADDR_MATCH_LO: avs_readdata <= {24'h0, match_lo_r};
                abu_pkg::ADDR_WAIT_EXIT: avs_readdata <= {30'h0, wait_exit_r, stop_wait_r};
                abu_pkg::ADDR_FLAG_CLR: avs_readdata <= {24'h0, permit_r, 7'h0};
                abu_pkg::ADDR_IRQ_STAT: avs_readdata <= {30'h0, ev_stat_r};
                abu_pkg::ADDR_IRQ_MASK: avs_readdata <= {30'h0, ev_mask_r};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    // break request toward the system integration unit
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            brk_out <= '0;
        end else if (clk_en) begin
            brk_out.req <= break_start;
            brk_out.opcode <= abu_pkg::SWI_OPCODE;
            brk_out.vector <= monitor_mode ? abu_pkg::VEC_MONITOR : abu_pkg::VEC_NORMAL;
        end
    end

    assign break_active = (state_r == abu_pkg::ST_BREAK);
    assign timer_freeze = break_active;
    assign watchdog_disable = break_active && test_v;
    assign wake_req = break_start && (in_wait || in_stop) && clk_en;
    // other blocks may clear their flags in a break only with permission
    assign flag_clear_permit_out = !break_active || permit_r;
endmodule

// [abu_chk.sv]
// port checker for the address breakpoint unit
`timescale 1ns/1ps
module abu_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    // processor side
    input wire abu_pkg::abu_cpu_type cpu_in,
    input wire logic monitor_mode,
    input wire logic in_wait,
    input wire logic in_stop,
    input wire logic test_voltage_pin,
    // outputs
    input wire abu_pkg::abu_brk_type brk_out,
    input wire logic break_active,
    input wire logic timer_freeze,
    input wire logic watchdog_disable,
    input wire logic wake_req,
    input wire logic flag_clear_permit_out
);
    logic en_r;
    logic [15:0] match_r;
    logic wr_ok;
    assign wr_ok = avs_write & ~avs_waitrequest & clk_en;
    // shadow of the enable bit and match address, taken from accepted writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            en_r <= 1'b0;
            match_r <= 16'h0000;
        end else if (wr_ok) begin
            if (avs_address == abu_pkg::ADDR_BRK_SC) en_r <= avs_writedata[abu_pkg::BIT_ENABLE];
            if (avs_address == abu_pkg::ADDR_MATCH_HI) match_r[15:8] <= avs_writedata[7:0];
            if (avs_address == abu_pkg::ADDR_MATCH_LO) match_r[7:0] <= avs_writedata[7:0];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_match_break: assert property (
        clk_en && en_r && cpu_in.pc_valid && cpu_in.instr_last && cpu_in.pc_addr == match_r |-> ##[1:2] break_active)
        else $error("match did not start a break");
    chk_req_vector: assert property (
        brk_out.req |-> brk_out.opcode == abu_pkg::SWI_OPCODE
        && brk_out.vector == (monitor_mode ? abu_pkg::VEC_MONITOR : abu_pkg::VEC_NORMAL))
        else $error("wrong opcode or vector");
    chk_req_pulse: assert property (
        $rose(break_active) |-> ##[0:2] brk_out.req ##1 !brk_out.req)
        else $error("break request not one pulse");
    chk_rti_ends: assert property (
        break_active && cpu_in.rti_done && clk_en |=> !break_active)
        else $error("return did not end break");
    chk_timer_freeze: assert property (timer_freeze == break_active)
        else $error("timer freeze differs from break");
    chk_wdog_on: assert property ((test_voltage_pin && clk_en)[*5] ##0 break_active |-> watchdog_disable)
        else $error("watchdog not disabled");
    chk_wdog_scope: assert property (watchdog_disable |-> break_active)
        else $error("watchdog disabled outside break");
    chk_wake_cause: assert property (wake_req |-> (in_wait || in_stop) ##1 break_active)
        else $error("wake without low power mode");
    chk_wake_on_break: assert property (
        $rose(break_active) && ($past(in_wait) || $past(in_stop)) |-> $past(wake_req))
        else $error("break in low power mode did not wake");
    chk_break_boundary: assert property ($rose(timer_freeze) |-> $past(cpu_in.instr_last))
        else $error("break began inside an instruction");
    chk_permit_out: assert property (!break_active |-> flag_clear_permit_out)
        else $error("flag clearing blocked outside break");
    chk_bus_wait: assert property (
        $rose(avs_read || avs_write) && clk_en |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait");
endmodule
bind abu_top abu_chk i_abu_chk (.mclk, .rst_n, .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_waitrequest, .cpu_in, .monitor_mode, .in_wait, .in_stop, .test_voltage_pin, .brk_out, .break_active,
    .timer_freeze, .watchdog_disable, .wake_req, .flag_clear_permit_out);

// [abu_cpu_model.sv]
// behavioural processor core driving program addresses
`timescale 1ns/1ps
module abu_cpu_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // bench control
    input wire logic slow,
    input wire logic rti_ok,
    // unit side
    input wire abu_pkg::abu_brk_type brk_out,
    input wire logic break_active,
    output abu_pkg::abu_cpu_type cpu_in
);
    logic [15:0] pc_r;
    logic [15:0] ret_r;
    logic [1:0] cyc_r;
    logic rti_r;
    logic [1:0] len;
    // slow instructions take three cycles so matches land mid-instruction
    assign len = slow ? 2'h2 : 2'h0;
    assign cpu_in = {pc_r, rst_n, cyc_r == len, rti_r};
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pc_r <= 16'h1000;
            ret_r <= 16'h0000;
            cyc_r <= 2'h0;
            rti_r <= 1'b0;
        end else begin
            rti_r <= 1'b0;
            if (brk_out.req) begin
                ret_r <= pc_r;
                pc_r <= brk_out.vector;
                cyc_r <= 2'h0;
            end else if (cyc_r != len) begin
                cyc_r <= cyc_r + 2'h1;
            end else begin
                cyc_r <= 2'h0;
                pc_r <= pc_r + 16'h1;
                // resume past the stopped instruction so it does not match again
                if (break_active && rti_ok && !rti_r) begin
                    rti_r <= 1'b1;
                    pc_r <= ret_r + 16'h1;
                end
            end
        end
    end
endmodule

// [address_breakpoint_unit_tb.sv]
// self-checking testbench for the address breakpoint unit
`timescale 1ns/1ps
module address_breakpoint_unit_tb;
    logic mclk, rst_n, clk_en, avs_read, avs_write, monitor_mode, in_wait, in_stop, test_voltage_pin, slow, rti_ok;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, r;
    logic avs_waitrequest, break_active, timer_freeze, watchdog_disable, wake_req, flag_clear_permit_out, irq;
    abu_pkg::abu_cpu_type cpu_in;
    abu_pkg::abu_brk_type brk_out;
    logic [7:0] q;
    logic [15:0] m;
    int mismatches = 0;
    int compares = 0;
    abu_top i_abu_top (.mclk, .rst_n, .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .cpu_in, .monitor_mode, .in_wait, .in_stop, .test_voltage_pin, .brk_out, .break_active,
        .timer_freeze, .watchdog_disable, .wake_req, .flag_clear_permit_out, .irq);
    abu_cpu_model i_abu_cpu_model (.mclk, .rst_n, .slow, .rti_ok, .brk_out, .break_active, .cpu_in);
    task automatic end_of_test;
        if (mismatches == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int n;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            $display("[ERR] %0t bus answer timed out", $time);
            end_of_test;
        end
    endtask
    task automatic wait_brk(input logic lvl);
        int n;
        n = 0;
        while (break_active !== lvl && n < 100) begin
            @(posedge mclk);
            n++;
        end
        if (break_active !== lvl) begin
            mismatches++;
            $display("[ERR] %0t break state wait timed out", $time);
            end_of_test;
        end
    endtask
    function automatic logic [15:0] exp_vector(input logic mon);
        return mon ? abu_pkg::VEC_MONITOR : abu_pkg::VEC_NORMAL;
    endfunction
    // rounds: 0 address match, 1 match while disabled, 2 software trigger
    task automatic round(input int i);
        int mode;
        mode = i % 3;
        r = $urandom;
        slow <= i[0];
        monitor_mode <= r[0];
        in_wait <= (i == 3);
        in_stop <= (i == 5);
        m = cpu_in.pc_addr + 16'h10 + {13'h0, r[3:1]};
        bus(1'b1, abu_pkg::ADDR_MATCH_HI, m[15:8]);
        bus(1'b1, abu_pkg::ADDR_MATCH_LO, m[7:0]);
        bus(1'b1, abu_pkg::ADDR_FLAG_CLR, {i[1], 7'h00});
        bus(1'b1, abu_pkg::ADDR_BRK_SC, mode == 0 ? 8'h80 : mode == 2 ? 8'h40 : 8'h00);
        // a disabled round lets the program counter run well past the match address
        if (mode == 1) repeat (80) @(posedge mclk);
        else wait_brk(1'b1);
        chk(break_active, mode != 1);
        if (mode == 1) begin
            bus(1'b0, abu_pkg::ADDR_BRK_SC, 8'h00);
            chk(q, 8'h00);
            return;
        end
        chk(brk_out.req, 1'b1);
        chk(brk_out.opcode, abu_pkg::SWI_OPCODE);
        m = exp_vector(monitor_mode);
        chk(brk_out.vector[15:8], m[15:8]);
        chk(brk_out.vector[7:0], m[7:0]);
        chk(flag_clear_permit_out, i[1]);
        bus(1'b0, abu_pkg::ADDR_BRK_SC, 8'h00);
        chk(q, mode == 0 ? 8'hc0 : 8'h40);
        bus(1'b0, abu_pkg::ADDR_IRQ_STAT, 8'h00);
        chk(q[0] & irq, 1'b1);
        // a low clock enable freezes the synchroniser, so the pin is not seen yet
        clk_en <= 1'b0;
        test_voltage_pin <= 1'b1;
        repeat (6) @(posedge mclk);
        chk(watchdog_disable, 1'b0);
        clk_en <= 1'b1;
        repeat (6) @(posedge mclk);
        chk(watchdog_disable, 1'b1);
        test_voltage_pin <= 1'b0;
        bus(1'b0, abu_pkg::ADDR_WAIT_EXIT, 8'h00);
        chk(q & (i == 3 ? 8'h02 : i == 5 ? 8'h01 : 8'h03), i == 3 ? 8'h02 : i == 5 ? 8'h01 : 8'h00);
        bus(1'b1, abu_pkg::ADDR_WAIT_EXIT, 8'h00);
        bus(1'b0, abu_pkg::ADDR_WAIT_EXIT, 8'h00);
        chk(q[1], 1'b0);
        bus(1'b1, abu_pkg::ADDR_IRQ_STAT, 8'h03);
        @(posedge mclk);
        chk(irq, 1'b0);
        // the handler clears the active flag before returning
        bus(1'b1, abu_pkg::ADDR_BRK_SC, 8'h00);
        bus(1'b0, abu_pkg::ADDR_BRK_SC, 8'h00);
        chk(q, 8'h00);
        in_wait <= 1'b0;
        in_stop <= 1'b0;
        rti_ok <= 1'b1;
        wait_brk(1'b0);
        rti_ok <= 1'b0;
        chk(break_active, 1'b0);
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        {rst_n, avs_read, avs_write, monitor_mode, in_wait, in_stop, test_voltage_pin, slow, rti_ok} = '0;
        clk_en = 1'b1;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        r = $urandom(32'h731b);
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        for (int a = 0; a < 7; a++) begin
            bus(1'b0, a[3:0], 8'h00);
            chk(q, 8'h00);
        end
        bus(1'b0, 4'hf, 8'h00);
        chk(q, 8'h00);
        bus(1'b1, abu_pkg::ADDR_IRQ_MASK, 8'h03);
        for (int i = 0; i < 6; i++) round(i);
        end_of_test;
    end
endmodule
